// ===== logic/pmcc_conv_config.sv
/*
  Power monitor conversion configuration: device and converter setup
  registers and the conversion sequencer that they steer.
  Assumes a register port from the serial frame logic on the same clock,
  and a converter that samples for as long as o_conv_busy marks a channel.
*/
// Contract
// - Writing 1 to device setup bit 15 restores all defaults; bit reads zero.
// - First conversion waits initial delay field times 2 ms; zero means none.
// - Device setup bits 14, 5 and 3-0 always read zero.
// - Device setup bit 4 selects shunt range: 0 wide, 1 narrow.
// - Mode field resets to Fh; codes 0h and 8h mean shutdown.
// - Codes 1h-7h start one triggered run over the channels their bits select.
// - Codes 9h-Fh convert continuously over the channels their bits select.
// - Bits 11-9 pick bus conversion time, reset 5h, 50 to 4120 us.
// - Bits 8-6 pick shunt conversion time, reset 5h, same eight codes.
// - Bits 5-3 pick temperature conversion time, reset 5h, same codes.
// - Converter setup reads FB68h after reset.
// - A triggered run from shutdown completes, then returns to shutdown.
// - Bits 2-0 pick averaging 1 to 1024; results update after averaging.
`timescale 1ns/1ps
`include "pmcc_defines.svh"
module pmcc_conv_config #(
  parameter int unsigned P_DLY_STEP_CYC = `PMCC_DLY_STEP_CYC,
  parameter int unsigned P_US_CYC = `PMCC_US_CYC
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  // Register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [5:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Converter control
  output logic o_shunt_range,
  output logic [2:0] o_avg_sel,
  output logic o_conv_start,
  output pmcc_pkg::pmcc_chan_type o_conv_channel,
  output logic [2:0] o_conv_time_sel,
  output logic o_conv_busy,
  output logic o_result_update
);
  import pmcc_pkg::*;

  // ************************************************************
  // Functions
  // ************************************************************
  function automatic logic [31:0] conv_cycles(input logic [2:0] ct);
    logic [31:0] us;
    us = 32'h0;
    case (ct)
      3'h0: us = `PMCC_CT0_US;
      3'h1: us = `PMCC_CT1_US;
      3'h2: us = `PMCC_CT2_US;
      3'h3: us = `PMCC_CT3_US;
      3'h4: us = `PMCC_CT4_US;
      3'h5: us = `PMCC_CT5_US;
      3'h6: us = `PMCC_CT6_US;
      default: us = `PMCC_CT7_US;
    endcase
    return us * P_US_CYC;
  endfunction

  function automatic logic [10:0] avg_target(input logic [2:0] sel);
    logic [10:0] n;
    n = `PMCC_AVG0;
    case (sel)
      3'h0: n = `PMCC_AVG0;
      3'h1: n = `PMCC_AVG1;
      3'h2: n = `PMCC_AVG2;
      3'h3: n = `PMCC_AVG3;
      3'h4: n = `PMCC_AVG4;
      3'h5: n = `PMCC_AVG5;
      3'h6: n = `PMCC_AVG6;
      default: n = `PMCC_AVG7;
    endcase
    return n;
  endfunction

  function automatic logic [2:0] chan_ct(input pmcc_chan_type ch, input logic [15:0] s);
    logic [2:0] ct;
    ct = s[`PMCC_TMP_CT_MSB:`PMCC_TMP_CT_LSB];
    case (ch)
      3'h1: ct = s[`PMCC_BUS_CT_MSB:`PMCC_BUS_CT_LSB];
      3'h2: ct = s[`PMCC_SH_CT_MSB:`PMCC_SH_CT_LSB];
      default: ct = s[`PMCC_TMP_CT_MSB:`PMCC_TMP_CT_LSB];
    endcase
    return ct;
  endfunction

  // ************************************************************
  // Setup registers
  // ************************************************************
  logic [7:0] dly_r;
  logic [7:0] dly_nxt;
  logic rng_r;
  logic rng_nxt;
  logic [15:0] setup_r;
  logic [15:0] setup_nxt;
  logic pend_r;
  logic pend_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic rvalid_r;
  logic soft_rst;
  logic wr_dev;
  logic wr_conv;
  logic trig_take;
  logic [15:0] dev_view;

  assign wr_dev = i_reg_wr && (i_reg_addr == `PMCC_ADDR_DEV_SETUP);
  assign wr_conv = i_reg_wr && (i_reg_addr == `PMCC_ADDR_CONV_SETUP);
  assign soft_rst = wr_dev && i_reg_wdata[`PMCC_DEV_RST_BIT];
  // Reserved bits and the reset bit are not stored, so they read zero
  assign dev_view = {2'h0, dly_r, 1'h0, rng_r, 4'h0};

  always_comb begin
    dly_nxt = dly_r;
    rng_nxt = rng_r;
    setup_nxt = setup_r;
    // A new trigger beats the take of an older one
    pend_nxt = pend_r && !trig_take;
    if (soft_rst) begin
      dly_nxt = `PMCC_DLY_RESET;
      rng_nxt = `PMCC_RANGE_RESET;
      setup_nxt = `PMCC_CONV_RESET;
      pend_nxt = 1'b0;
    end else if (wr_dev) begin
      dly_nxt = i_reg_wdata[`PMCC_DLY_MSB:`PMCC_DLY_LSB];
      rng_nxt = i_reg_wdata[`PMCC_RANGE_BIT];
    end else if (wr_conv) begin
      setup_nxt = i_reg_wdata;
      if (!i_reg_wdata[`PMCC_MODE_CONT_BIT] && (i_reg_wdata[`PMCC_MODE_EN_MSB:`PMCC_MODE_EN_LSB] != 3'h0)) begin
        pend_nxt = 1'b1;
      end
    end
  end

  // Reads return the value held before a write in the same cycle
  always_comb begin
    rdata_nxt = rdata_r;
    if (i_reg_rd) begin
      case (i_reg_addr)
        `PMCC_ADDR_DEV_SETUP: rdata_nxt = dev_view;
        `PMCC_ADDR_CONV_SETUP: rdata_nxt = setup_r;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      dly_r <= `PMCC_DLY_RESET;
      rng_r <= `PMCC_RANGE_RESET;
      setup_r <= `PMCC_CONV_RESET;
      pend_r <= 1'b0;
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else if (i_clk_en) begin
      dly_r <= dly_nxt;
      rng_r <= rng_nxt;
      setup_r <= setup_nxt;
      pend_r <= pend_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= i_reg_rd;
    end
  end

  // ************************************************************
  // Conversion sequencer
  // ************************************************************
  pmcc_state_type state_r;
  pmcc_state_type state_nxt;
  pmcc_chan_type rem_r;
  pmcc_chan_type rem_nxt;
  pmcc_chan_type chan_r;
  pmcc_chan_type chan_nxt;
  pmcc_chan_type pass_en_r;
  pmcc_chan_type pass_en_nxt;
  pmcc_chan_type en;
  pmcc_chan_type next_en;
  pmcc_chan_type low;
  logic [10:0] avg_r;
  logic [10:0] avg_nxt;
  logic [2:0] ct_r;
  logic [2:0] ct_nxt;
  logic trun_r;
  logic trun_nxt;
  logic start_nxt;
  logic upd_nxt;
  logic start_r;
  logic upd_r;
  logic cont_run;
  logic avg_done;
  logic tmr_load;
  logic [31:0] tmr_count;
  logic tmr_done;

  // Mode bits 14-12 select channels, bit 15 continuous; codes 0h and 8h select none
  assign en = setup_r[`PMCC_MODE_EN_MSB:`PMCC_MODE_EN_LSB];
  assign cont_run = setup_r[`PMCC_MODE_CONT_BIT] && (en != 3'h0);
  assign trig_take = (state_r == ST_IDLE) && (pend_r || cont_run);
  assign avg_done = ((avg_r + 11'h001) == avg_target(setup_r[`PMCC_AVG_MSB:`PMCC_AVG_LSB]));
  assign low = rem_r & (~rem_r + 3'h1);
  // A triggered run keeps its channel set even if the mode changes under it
  assign next_en = trun_r ? pass_en_r : en;

  always_comb begin
    state_nxt = state_r;
    rem_nxt = rem_r;
    chan_nxt = chan_r;
    pass_en_nxt = pass_en_r;
    avg_nxt = avg_r;
    ct_nxt = ct_r;
    trun_nxt = trun_r;
    start_nxt = 1'b0;
    upd_nxt = 1'b0;
    tmr_load = 1'b0;
    tmr_count = 32'h0;
    case (state_r)
      ST_IDLE: begin
        if (trig_take) begin
          trun_nxt = !cont_run;
          tmr_load = 1'b1;
          tmr_count = 32'(dly_r) * P_DLY_STEP_CYC;
          state_nxt = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (tmr_done) begin
          pass_en_nxt = en;
          rem_nxt = en;
          avg_nxt = 11'h000;
          state_nxt = (en == 3'h0) ? ST_IDLE : ST_SELECT;
        end
      end
      ST_SELECT: begin
        chan_nxt = low;
        rem_nxt = rem_r & ~low;
        ct_nxt = chan_ct(low, setup_r);
        tmr_load = 1'b1;
        // One cycle short: done is seen a cycle late, so busy lasts the full count
        tmr_count = conv_cycles(chan_ct(low, setup_r)) - 32'h1;
        start_nxt = 1'b1;
        state_nxt = ST_CONVERT;
      end
      ST_CONVERT: begin
        if (tmr_done) begin
          chan_nxt = 3'h0;
          state_nxt = (rem_r == 3'h0) ? ST_PASS : ST_SELECT;
        end
      end
      ST_PASS: begin
        if (avg_done) begin
          upd_nxt = 1'b1;
          avg_nxt = 11'h000;
          if (!trun_r && cont_run) begin
            pass_en_nxt = en;
            rem_nxt = en;
            state_nxt = ST_SELECT;
          end else begin
            state_nxt = ST_IDLE;
          end
        end else begin
          avg_nxt = avg_r + 11'h001;
          pass_en_nxt = next_en;
          rem_nxt = next_en;
          state_nxt = (next_en == 3'h0) ? ST_IDLE : ST_SELECT;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (soft_rst) begin
      state_nxt = ST_IDLE;
      rem_nxt = 3'h0;
      chan_nxt = 3'h0;
      pass_en_nxt = 3'h0;
      avg_nxt = 11'h000;
      ct_nxt = 3'h0;
      trun_nxt = 1'b0;
      start_nxt = 1'b0;
      upd_nxt = 1'b0;
      tmr_load = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= ST_IDLE;
      rem_r <= 3'h0;
      chan_r <= 3'h0;
      pass_en_r <= 3'h0;
      avg_r <= 11'h000;
      ct_r <= 3'h0;
      trun_r <= 1'b0;
      start_r <= 1'b0;
      upd_r <= 1'b0;
    end else if (i_clk_en) begin
      state_r <= state_nxt;
      rem_r <= rem_nxt;
      chan_r <= chan_nxt;
      pass_en_r <= pass_en_nxt;
      avg_r <= avg_nxt;
      ct_r <= ct_nxt;
      trun_r <= trun_nxt;
      start_r <= start_nxt;
      upd_r <= upd_nxt;
    end
  end

  pmcc_timer #(
    .W(32)
  ) u_timer (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_clk_en(i_clk_en),
    .i_load(tmr_load),
    .i_clear(soft_rst),
    .i_count(tmr_count),
    .o_done(tmr_done)
  );

  // ************************************************************
  // Outputs
  // ************************************************************
  assign o_reg_rdata = rdata_r;
  assign o_reg_rvalid = rvalid_r;
  assign o_shunt_range = rng_r;
  assign o_avg_sel = setup_r[`PMCC_AVG_MSB:`PMCC_AVG_LSB];
  assign o_conv_start = start_r;
  assign o_conv_channel = chan_r;
  assign o_conv_time_sel = ct_r;
  assign o_conv_busy = (state_r == ST_CONVERT);
  assign o_result_update = upd_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  // Interval checker: cycles spent since the last timer load
  logic [31:0] cyc_r;
  logic [31:0] ld_r;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cyc_r <= 32'h0;
      ld_r <= 32'h0;
    end else if (i_clk_en) begin
      if (tmr_load) begin
        cyc_r <= 32'h0;
        ld_r <= tmr_count;
      end else begin
        cyc_r <= cyc_r + 32'h1;
      end
    end
  end

  a_soft_reset: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_clk_en)
    soft_rst |=> (dly_r == `PMCC_DLY_RESET) && !rng_r && (setup_r == `PMCC_CONV_RESET) && (state_r == ST_IDLE))
    else $error("soft reset did not restore defaults");
  a_delay_length: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_clk_en)
    (state_r == ST_DELAY) && tmr_done |-> (cyc_r == ld_r) && (ld_r == 32'(dly_r) * P_DLY_STEP_CYC))
    else $error("initial delay length wrong");
  a_reserved_zero: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_clk_en)
    i_reg_rd && (i_reg_addr == `PMCC_ADDR_DEV_SETUP) |=> (o_reg_rdata[15:14] == 2'h0) && !o_reg_rdata[5]
      && (o_reg_rdata[3:0] == 4'h0) && o_reg_rvalid)
    else $error("reserved device setup bits not zero");
  a_range_follow: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_clk_en)
    wr_dev && !soft_rst |=> o_shunt_range == $past(i_reg_wdata[`PMCC_RANGE_BIT]))
    else $error("shunt range not taken from write");
  a_reset_value: assert property (@(posedge i_clock) disable iff (!i_nrst)
    !$past(i_nrst) |-> (setup_r == `PMCC_CONV_RESET) && (state_r == ST_IDLE))
    else $error("converter setup reset value wrong");
  a_shutdown_stays: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_clk_en)
    (state_r == ST_IDLE) && (en == 3'h0) && !pend_r && !i_reg_wr |=> state_r == ST_IDLE)
    else $error("shutdown mode left idle");
  a_trigger_runs: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_clk_en)
    (state_r == ST_IDLE) && !cont_run && !pend_r && pend_nxt |=> pend_r ##1 (state_r == ST_DELAY) && trun_r && !pend_r)
    else $error("triggered write did not start one run");
  a_trigger_ends: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_clk_en)
    (state_r == ST_PASS) && avg_done && trun_r && !soft_rst |=> (state_r == ST_IDLE) && o_result_update)
    else $error("triggered run did not return to shutdown");
  a_cont_restart: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_clk_en)
    (state_r == ST_PASS) && avg_done && !trun_r && cont_run && !soft_rst |=> (state_r == ST_SELECT) ##1 o_conv_start)
    else $error("continuous mode did not restart");
  a_channel_legal: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_clk_en)
    o_conv_start |-> $onehot(o_conv_channel) && ((o_conv_channel & pass_en_r) != 3'h0) && o_conv_busy)
    else $error("conversion on unselected channel");
  a_conv_length: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_clk_en)
    (state_r == ST_CONVERT) && tmr_done |-> (cyc_r == ld_r) && ((ld_r + 32'h1) == conv_cycles(o_conv_time_sel)))
    else $error("conversion time wrong");
  a_avg_update: assert property (@(posedge i_clock) disable iff (!i_nrst || !i_clk_en)
    o_result_update |-> $past(state_r) == ST_PASS && ($past(avg_r) + 11'h001) == avg_target(o_avg_sel))
    else $error("results updated before averaging ended");

  c_trig_run: cover property (@(posedge i_clock) disable iff (!i_nrst)
    (state_r == ST_PASS) && avg_done && trun_r);
  c_cont_avg: cover property (@(posedge i_clock) disable iff (!i_nrst)
    o_result_update && !trun_r && (o_avg_sel != 3'h0));
  c_delayed: cover property (@(posedge i_clock) disable iff (!i_nrst)
    (state_r == ST_DELAY) && tmr_done && (dly_r != 8'h00));
  c_soft_rst: cover property (@(posedge i_clock) disable iff (!i_nrst)
    soft_rst && (state_r == ST_CONVERT));

endmodule

// ===== logic/pmcc_defines.svh
/*
  Constants of the power monitor conversion configuration block: register
  addresses, field positions, reset values and timing figures.
  Assumes inclusion by bare name from the block's design files.
*/
`ifndef PMCC_DEFINES_SVH
`define PMCC_DEFINES_SVH

// ************************************************************
// Register addresses
// ************************************************************
`define PMCC_ADDR_DEV_SETUP 6'h00
`define PMCC_ADDR_CONV_SETUP 6'h01

// ************************************************************
// Device setup fields
// ************************************************************
`define PMCC_DEV_RST_BIT 15
`define PMCC_DLY_MSB 13
`define PMCC_DLY_LSB 6
`define PMCC_RANGE_BIT 4
`define PMCC_DLY_RESET 8'h00
`define PMCC_RANGE_RESET 1'h0

// ************************************************************
// Converter setup fields
// ************************************************************
`define PMCC_CONV_RESET 16'hFB68
`define PMCC_MODE_CONT_BIT 15
`define PMCC_MODE_EN_MSB 14
`define PMCC_MODE_EN_LSB 12
`define PMCC_BUS_CT_MSB 11
`define PMCC_BUS_CT_LSB 9
`define PMCC_SH_CT_MSB 8
`define PMCC_SH_CT_LSB 6
`define PMCC_TMP_CT_MSB 5
`define PMCC_TMP_CT_LSB 3
`define PMCC_AVG_MSB 2
`define PMCC_AVG_LSB 0

// ************************************************************
// Timing
// ************************************************************
`define PMCC_CLK_MHZ 100
`define PMCC_US_CYC (`PMCC_CLK_MHZ)
`define PMCC_DLY_STEP_MS 2
`define PMCC_DLY_STEP_CYC (`PMCC_DLY_STEP_MS * 1000 * `PMCC_CLK_MHZ)
`define PMCC_CT0_US 50
`define PMCC_CT1_US 84
`define PMCC_CT2_US 150
`define PMCC_CT3_US 280
`define PMCC_CT4_US 540
`define PMCC_CT5_US 1052
`define PMCC_CT6_US 2074
`define PMCC_CT7_US 4120

// ************************************************************
// Averaging counts
// ************************************************************
`define PMCC_AVG0 11'h001
`define PMCC_AVG1 11'h004
`define PMCC_AVG2 11'h010
`define PMCC_AVG3 11'h040
`define PMCC_AVG4 11'h080
`define PMCC_AVG5 11'h100
`define PMCC_AVG6 11'h200
`define PMCC_AVG7 11'h400

`endif

// ===== logic/pmcc_pkg.sv
/*
  Types of the power monitor conversion configuration block.
  Assumes nothing of its surroundings.
*/
package pmcc_pkg;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DELAY = 5'h02,
    ST_SELECT = 5'h04,
    ST_CONVERT = 5'h08,
    ST_PASS = 5'h10
  } pmcc_state_type;

  // Channel mask: bit 0 bus voltage, bit 1 shunt voltage, bit 2 temperature
  typedef logic [2:0] pmcc_chan_type;

endpackage

// ===== logic/pmcc_timer.sv
/*
  Down-counting interval timer for the conversion sequencer.
  Assumes the loader never loads while a count is still running, except
  through the clear input.
*/
`timescale 1ns/1ps
module pmcc_timer #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  // Control
  input wire logic i_load,
  input wire logic i_clear,
  input wire logic [W-1:0] i_count,
  // Status
  output logic o_done
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic done_r;
  logic done_nxt;

  // A load of zero ends on the next edge, so no interval is shorter than one cycle
  always_comb begin
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (i_clear) begin
      cnt_nxt = '0;
    end else if (i_load) begin
      cnt_nxt = i_count;
      done_nxt = (i_count == '0);
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
      done_nxt = (cnt_r == {{(W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else if (i_clk_en) begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign o_done = done_r;

endmodule

// ===== verification/pmcc_host_model.sv
/*
  Host model: drives the block's register strobe port as the serial main would.
  Assumes one clock shared with the design and one call at a time.
*/
`timescale 1ns/1ps
module pmcc_host_model (
  // Clock
  input wire logic i_clock,
  // Register port drive
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [5:0] o_reg_addr,
  output logic [15:0] o_reg_wdata
);
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 6'h00;
    o_reg_wdata = 16'h0000;
  end

  // Released data shows the inverse, so a stale word never passes for a fresh one
  task automatic write(input logic [5:0] a, input logic [15:0] d);
    @(posedge i_clock);
    o_reg_wr <= 1'b1;
    o_reg_addr <= a;
    o_reg_wdata <= d;
    @(posedge i_clock);
    o_reg_wr <= 1'b0;
    o_reg_wdata <= ~d;
  endtask

  task automatic read(input logic [5:0] a);
    @(posedge i_clock);
    o_reg_rd <= 1'b1;
    o_reg_addr <= a;
    @(posedge i_clock);
    o_reg_rd <= 1'b0;
  endtask
endmodule

// ===== verification/power_monitor_conversion_config_tb_top.sv
/*
  Self-checking bench of the conversion configuration block.
  Assumes short sim parameters: delay step 10 cycles, 1 cycle per microsecond.
*/
`timescale 1ns/1ps
module power_monitor_conversion_config_tb_top;
  import pmcc_pkg::*;
  localparam int DLY = 10;
  logic i_clock;
  logic i_nrst;
  logic i_clk_en;
  logic wr, rd;
  logic [5:0] addr;
  logic [15:0] wdata, o_reg_rdata;
  logic o_reg_rvalid, o_shunt_range, o_conv_start, o_conv_busy, o_result_update;
  logic [2:0] o_avg_sel, o_conv_time_sel;
  pmcc_chan_type o_conv_channel;
  int checks = 0;
  int bad_count = 0;
  int st_n = 0;
  int upd_n = 0;
  int busy_n = 0;
  bit track = 0;
  logic busy_q = 1'b0;
  logic [12:0] dur = 13'h0000;
  logic [15:0] rd_q[$];
  logic [18:0] cv_q[$];
  logic [2:0] ct[3];
  logic [12:0] us_tab[8] = '{13'h0032, 13'h0054, 13'h0096, 13'h0118, 13'h021C, 13'h041C, 13'h081A, 13'h1018};

  pmcc_host_model pmcc_host_model_inst (.i_clock(i_clock), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr),
    .o_reg_wdata(wdata));
  pmcc_conv_config #(.P_DLY_STEP_CYC(DLY), .P_US_CYC(1)) pmcc_conv_config_inst (.i_clock(i_clock),
    .i_nrst(i_nrst), .i_clk_en(i_clk_en), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .o_shunt_range(o_shunt_range), .o_avg_sel(o_avg_sel), .o_conv_start(o_conv_start),
    .o_conv_channel(o_conv_channel), .o_conv_time_sel(o_conv_time_sel), .o_conv_busy(o_conv_busy),
    .o_result_update(o_result_update));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic rd_exp(input logic [5:0] a, input logic [15:0] e);
    rd_q.push_back(e);
    pmcc_host_model_inst.read(a);
  endtask

  // Channels convert in fixed order bus, shunt, temperature
  task automatic push_pass(input logic [2:0] en);
    for (int k = 0; k < 3; k++) begin
      if (en[k]) begin
        cv_q.push_back({3'(1 << k), ct[k], us_tab[ct[k]]});
      end
    end
  endtask

  task automatic wait_upd();
    int n;
    n = 0;
    while (o_result_update !== 1'b1 && n < 20000) begin
      @(posedge i_clock);
      n++;
    end
    check("upd_wait", n < 20000, 1);
  endtask

  task automatic idle_checks(input int u0);
    int s0;
    s0 = st_n;
    repeat (200) @(posedge i_clock);
    check("idle", st_n, s0);
    check("updates", upd_n - u0, 1);
    check("queue", cv_q.size(), 0);
  endtask

  // ************************************************************
  // Output watcher
  // ************************************************************
  always @(posedge i_clock) begin
    logic [18:0] e;
    if (o_reg_rvalid === 1'b1) begin
      check("rdata", o_reg_rdata, (rd_q.size() > 0) ? rd_q.pop_front() : 16'hDEAD);
    end
    if (track && o_conv_start === 1'b1) begin
      st_n++;
      e = (cv_q.size() > 0) ? cv_q.pop_front() : 19'h7FFFF;
      check("channel", o_conv_channel, e[18:16]);
      check("time_sel", o_conv_time_sel, e[15:13]);
      dur = e[12:0];
      busy_n = 0;
    end
    if (o_conv_busy === 1'b1) begin
      busy_n++;
    end else if (busy_q === 1'b1 && track) begin
      check("busy_len", busy_n, dur);
    end
    busy_q = o_conv_busy;
    if (track && o_result_update === 1'b1) begin
      upd_n++;
    end
  end

  initial begin
    repeat (100000) @(posedge i_clock);
    bad_count++;
    complete_run();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    logic [15:0] r, w;
    int lat, lat_p, u0, n;
    i_nrst = 1'b0;
    i_clk_en = 1'b1;
    r = 16'($urandom(32'h7DA91ACC));
    repeat (10) @(posedge i_clock);
    i_nrst <= 1'b1;
    rd_exp(6'h00, 16'h0000);
    rd_exp(6'h01, 16'hFB68);
    rd_exp(6'h3E, 16'h0000);
    pmcc_host_model_inst.write(6'h01, 16'h0000);
    wait_upd();
    repeat (4) @(posedge i_clock);
    track = 1;
    r = 16'($urandom) & 16'h7FFF;
    pmcc_host_model_inst.write(6'h00, r);
    rd_exp(6'h00, r & 16'h3FD0);
    check("range", o_shunt_range, r[4]);
    lat_p = 0;
    for (int m = 1; m < 8; m++) begin
      ct[0] = 3'(m);
      ct[1] = 3'(m + 3);
      ct[2] = 3'(m + 5);
      w = {4'(m), ct[0], ct[1], ct[2], 3'h0};
      pmcc_host_model_inst.write(6'h00, 16'(m << 6));
      push_pass(3'(m));
      u0 = upd_n;
      pmcc_host_model_inst.write(6'h01, w); // one write per triggered result
      rd_exp(6'h01, w);
      lat = 0;
      while (o_conv_start !== 1'b1 && lat < 1000) begin
        @(posedge i_clock);
        lat++;
      end
      if (m > 1) begin
        check("delay_step", lat - lat_p, DLY);
      end
      lat_p = lat;
      wait_upd();
      idle_checks(u0);
    end
    pmcc_host_model_inst.write(6'h00, 16'h0000);
    ct = '{3'h0, 3'h0, 3'h0};
    for (int m = 9; m < 16; m++) begin
      u0 = upd_n;
      lat = st_n + 3 * (m[0] + m[1] + m[2]) + 1;
      repeat (4) push_pass(3'(m));
      pmcc_host_model_inst.write(6'h01, 16'(m << 12) | 16'h0001);
      @(posedge i_clock);
      check("avg", o_avg_sel, 3'h1);
      n = 0;
      while (st_n < lat && n < 20000) begin
        @(posedge i_clock);
        n++;
      end
      pmcc_host_model_inst.write(6'h01, (m % 2 == 1) ? 16'h0001 : 16'h8001);
      wait_upd();
      idle_checks(u0);
    end
    track = 0;
    pmcc_host_model_inst.write(6'h00, 16'h0010);
    pmcc_host_model_inst.write(6'h00, 16'hFFFF);
    rd_exp(6'h00, 16'h0000);
    rd_exp(6'h01, 16'hFB68);
    check("range_rst", o_shunt_range, 1'b0);
    repeat (3) @(posedge i_clock);
    complete_run();
  end
endmodule
